// ===== hdl/charge_counter_pkg.sv
// constants, register map and field layout of the charge counter readout
package charge_counter_pkg;

    // ****************************************
    // bus and counter geometry
    // ****************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int COUNT_W = 16;
    localparam int BYTE_W = 8;
    localparam int NUM_CH = 3;
    localparam int PRE_W = 6;
    localparam int SEL_W = 2;

    // ****************************************
    // register indexes; byte address is four times the index
    // ****************************************
    localparam logic [7:0] IDX_RAIL_A_CHARGE_HIGH = 8'h13;
    localparam logic [7:0] IDX_RAIL_A_CHARGE_LOW = 8'h14;
    localparam logic [7:0] IDX_RAIL_B_ACTIVE_CHARGE_HIGH = 8'h15;
    localparam logic [7:0] IDX_RAIL_B_ACTIVE_CHARGE_LOW = 8'h16;
    localparam logic [7:0] IDX_RAIL_B_SLEEP_CHARGE_HIGH = 8'h17;
    localparam logic [7:0] IDX_RAIL_B_SLEEP_CHARGE_LOW = 8'h18;
    localparam logic [7:0] IDX_CHARGE_COUNTER_CONTROL = 8'h1A;

    // channel order: 0 rail A, 1 rail B active, 2 rail B sleep
    localparam logic [7:0] HIGH_IDX [NUM_CH] = '{IDX_RAIL_A_CHARGE_HIGH,
        IDX_RAIL_B_ACTIVE_CHARGE_HIGH, IDX_RAIL_B_SLEEP_CHARGE_HIGH};
    localparam logic [7:0] LOW_IDX [NUM_CH] = '{IDX_RAIL_A_CHARGE_LOW,
        IDX_RAIL_B_ACTIVE_CHARGE_LOW, IDX_RAIL_B_SLEEP_CHARGE_LOW};

    // ****************************************
    // reset values and fields
    // ****************************************
    localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
    localparam logic [SEL_W-1:0] PRESCALE_RESET = 2'h0;
    localparam int PRESCALE_LSB = 0;
    // pulses per step minus one, per pulse_prescale_select value: 1, 4, 16, 64
    localparam logic [PRE_W-1:0] PRESCALE_LIMIT [4] = '{6'h00, 6'h03, 6'h0F, 6'h3F};

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        byte_addr = ADDR_W'({idx, 2'b00});
    endfunction : byte_addr

endpackage : charge_counter_pkg

// ===== hdl/charge_channel.sv
// one charge counter: pulse synchroniser, prescaler, held counter, low-byte shadow
`timescale 1ns/100ps
module charge_channel
    import charge_counter_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic pulse_async,
    input wire logic count_enable,
    input wire logic [charge_counter_pkg::SEL_W-1:0] prescale_sel,
    input wire logic hold,
    input wire logic take_shadow,
    output logic [charge_counter_pkg::COUNT_W-1:0] count_q,
    output logic [charge_counter_pkg::BYTE_W-1:0] shadow_q,
    output logic pend_q
);

    // ****************************************
    // state
    // ****************************************
    logic sync1_q, sync2_q, prev_q;
    logic [PRE_W-1:0] pre_q, pre_d;
    logic [COUNT_W-1:0] count_d;
    logic [BYTE_W-1:0] shadow_d;
    logic pend_d;
    logic pulse_edge, step;

    always_comb
    begin
        pulse_edge = sync2_q & ~prev_q & count_enable;
        step = pulse_edge & (pre_q >= PRESCALE_LIMIT[prescale_sel]);
        pre_d = pre_q;
        if (pulse_edge)
        begin
            pre_d = step ? '0 : pre_q + PRE_W'(1);
        end
        count_d = count_q;
        pend_d = pend_q;
        if (hold)
        begin
            // only one held step survives; more are lost, a known limitation
            if (step)
            begin
                pend_d = 1'b1;
            end
        end
        else
        begin
            count_d = count_q + COUNT_W'(step) + COUNT_W'(pend_q);
            pend_d = 1'b0;
        end
        // count is frozen by the same access, so the copy is coherent
        shadow_d = take_shadow ? count_q[BYTE_W-1:0] : shadow_q;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
            pre_q <= '0;
            count_q <= COUNT_RESET;
            shadow_q <= BYTE_RESET;
            pend_q <= 1'b0;
        end
        else
        begin
            sync1_q <= pulse_async;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
            pre_q <= pre_d;
            count_q <= count_d;
            shadow_q <= shadow_d;
            pend_q <= pend_d;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_hold_freezes: assert property (@(posedge clk) disable iff (srst)
        hold |=> $stable(count_q))
        else $error("counter moved while held");

    a_shadow_copy: assert property (@(posedge clk) disable iff (srst)
        take_shadow |=> shadow_q == $past(count_q[BYTE_W-1:0]))
        else $error("shadow not loaded from live low byte");

    a_no_step_idle: assert property (@(posedge clk) disable iff (srst)
        (!step && !pend_q) |=> $stable(count_q))
        else $error("counter moved without a prescaled step");

    a_pend_applied: assert property (@(posedge clk) disable iff (srst)
        (pend_q && !hold) |=> (count_q != $past(count_q)) && !pend_q)
        else $error("held step not applied after release");

endmodule : charge_channel

// ===== hdl/charge_counter_readout.sv
// avalon-mm register bank exposing three held, shadowed charge counters
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module charge_counter_readout
    import charge_counter_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [charge_counter_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [charge_counter_pkg::DATA_W-1:0] writedata,
    output logic [charge_counter_pkg::DATA_W-1:0] readdata,
    output logic waitrequest,
    input wire logic pulse_rail_a,
    input wire logic pulse_rail_b,
    input wire logic sleep_mode
);

    // ****************************************
    // declarations
    // ****************************************
    logic [DATA_W-1:0] readdata_q, readdata_d;
    logic wait_q, wait_d;
    logic [SEL_W-1:0] prescale_q, prescale_d;
    logic request, capture, complete;
    logic [NUM_CH-1:0] pulse_vec, enable_vec, hold_vec, shadow_vec, pend_vec;
    logic [NUM_CH-1:0] hit_high, hit_low;
    logic hit_ctrl;
    logic [COUNT_W-1:0] count_arr [NUM_CH];
    logic [BYTE_W-1:0] shadow_arr [NUM_CH];

    assign readdata = readdata_q;
    assign waitrequest = wait_q;

    // ****************************************
    // pulse routing
    // ****************************************
    // rail B pulses go to the counter of the current energy mode
    assign pulse_vec = {pulse_rail_b, pulse_rail_b, pulse_rail_a};
    assign enable_vec = {sleep_mode, ~sleep_mode, 1'b1};

    // ****************************************
    // address decode
    // ****************************************
    always_comb
    begin
        request = read | write;
        capture = request & wait_q;
        complete = request & ~wait_q;
        hit_ctrl = address == byte_addr(IDX_CHARGE_COUNTER_CONTROL);
        for (int i = 0; i < NUM_CH; i++)
        begin
            hit_high[i] = address == byte_addr(HIGH_IDX[i]);
            hit_low[i] = address == byte_addr(LOW_IDX[i]);
            // any access to a counter byte freezes it; the host keeps these short
            hold_vec[i] = request & (hit_high[i] | hit_low[i]);
            shadow_vec[i] = capture & read & hit_high[i];
        end
    end

    // ****************************************
    // counters
    // ****************************************
    generate
        for (genvar g = 0; g < NUM_CH; g++)
        begin : gen_ch
            charge_channel i_charge_channel (
                .clk(clk),
                .srst(srst),
                .pulse_async(pulse_vec[g]),
                .count_enable(enable_vec[g]),
                .prescale_sel(prescale_q),
                .hold(hold_vec[g]),
                .take_shadow(shadow_vec[g]),
                .count_q(count_arr[g]),
                .shadow_q(shadow_arr[g]),
                .pend_q(pend_vec[g])
            );
        end
    endgenerate

    // ****************************************
    // bus slave: one wait cycle, then completion
    // ****************************************
    always_comb
    begin
        wait_d = ~capture;
        readdata_d = readdata_q;
        prescale_d = prescale_q;
        if (capture & read)
        begin
            // unmapped addresses and reserved bits read as zero
            readdata_d = '0;
            if (hit_ctrl)
            begin
                readdata_d[PRESCALE_LSB +: SEL_W] = prescale_q;
            end
            else if (hit_high[0])
            begin
                readdata_d[BYTE_W-1:0] = count_arr[0][COUNT_W-1:BYTE_W];
            end
            else if (hit_low[0])
            begin
                readdata_d[BYTE_W-1:0] = shadow_arr[0];
            end
            else if (hit_high[1])
            begin
                readdata_d[BYTE_W-1:0] = count_arr[1][COUNT_W-1:BYTE_W];
            end
            else if (hit_low[1])
            begin
                readdata_d[BYTE_W-1:0] = shadow_arr[1];
            end
            else if (hit_high[2])
            begin
                readdata_d[BYTE_W-1:0] = count_arr[2][COUNT_W-1:BYTE_W];
            end
            else if (hit_low[2])
            begin
                readdata_d[BYTE_W-1:0] = shadow_arr[2];
            end
        end
        // counter bytes ignore writes; only the control register takes one
        if (complete & write & hit_ctrl)
        begin
            prescale_d = writedata[PRESCALE_LSB +: SEL_W];
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wait_q <= 1'b1;
            readdata_q <= '0;
            prescale_q <= PRESCALE_RESET;
        end
        else
        begin
            wait_q <= wait_d;
            readdata_q <= readdata_d;
            prescale_q <= prescale_d;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking

    default disable iff (srst);

    a_wait_answer: assert property (
        (request && waitrequest) |=> !waitrequest)
        else $error("no answer one cycle after request");

    a_wait_single: assert property (
        !waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");

    a_low_shadow_read: assert property (
        (read && waitrequest && address == byte_addr(IDX_RAIL_A_CHARGE_LOW))
        |=> readdata == DATA_W'($past(shadow_arr[0])))
        else $error("rail A low byte did not return shadow");

    a_pair_coherent: assert property (
        (read && waitrequest && address == byte_addr(IDX_RAIL_B_ACTIVE_CHARGE_HIGH))
        |=> shadow_arr[1] == $past(count_arr[1][BYTE_W-1:0])
        && readdata == DATA_W'($past(count_arr[1][COUNT_W-1:BYTE_W])))
        else $error("active rail B high read not coherent with shadow");

    a_sleep_high_read: assert property (
        (read && waitrequest && address == byte_addr(IDX_RAIL_B_SLEEP_CHARGE_HIGH))
        |=> readdata == DATA_W'($past(count_arr[2][COUNT_W-1:BYTE_W])))
        else $error("sleep rail B high byte read wrong");

    a_rail_a_high: assert property (
        (read && waitrequest && address == byte_addr(IDX_RAIL_A_CHARGE_HIGH))
        |=> readdata == DATA_W'($past(count_arr[0][COUNT_W-1:BYTE_W])))
        else $error("rail A high byte read wrong");

    a_low_reset_zero: assert property (
        $past(srst) |-> (count_arr[0] == COUNT_RESET) && (count_arr[1] == COUNT_RESET)
        && (shadow_arr[1] == BYTE_RESET))
        else $error("counters not zero after reset");

    a_hold_counter: assert property (
        (request && address == byte_addr(IDX_RAIL_B_SLEEP_CHARGE_LOW))
        |=> $stable(count_arr[2]))
        else $error("sleep counter moved while addressed");

    a_release_pending: assert property (
        (pend_vec[0] && !hold_vec[0]) |=> !pend_vec[0])
        else $error("hold not released after access");

    a_ctrl_write: assert property (
        (write && !waitrequest && hit_ctrl) |=> prescale_q == $past(writedata[PRESCALE_LSB +: SEL_W]))
        else $error("prescale select not taken at write completion");

    a_sleep_steer: assert property (
        (sleep_mode && !pend_vec[1]) |=> $stable(count_arr[1]))
        else $error("active rail B counter moved in sleep mode");

    a_active_steer: assert property (
        (!sleep_mode && !pend_vec[2]) |=> $stable(count_arr[2]))
        else $error("sleep rail B counter moved in active mode");

    a_write_no_data: assert property (
        (write && waitrequest) |=> $stable(readdata))
        else $error("write access changed read data");

    c_high_then_low: cover property (
        (read && !waitrequest && address == byte_addr(IDX_RAIL_A_CHARGE_HIGH))
        ##[1:10] (read && !waitrequest && address == byte_addr(IDX_RAIL_A_CHARGE_LOW)));

    c_pending_step: cover property (pend_vec[0] ##1 !hold_vec[0]);

    c_sleep_count: cover property (sleep_mode ##1 $changed(count_arr[2]));

    c_ctrl_write: cover property (write && !waitrequest && hit_ctrl);

endmodule : charge_counter_readout

// ===== bench/converter_pulse_source.sv
// converter pulse source feeding one charge counter pulse input
`timescale 1ns/100ps
module converter_pulse_source
(
    input wire logic clk,
    output logic pulse
);
    initial pulse = 1'b0;

    // ****************************************
    // pulse train
    // ****************************************
    // one cycle high and one cycle low, the shortest shape the synchroniser accepts
    task automatic send(input int k);
        for (int i = 0; i < k; i++)
        begin
            @(posedge clk);
            pulse <= 1'b1;
            @(posedge clk);
            pulse <= 1'b0;
        end
        // synchroniser and edge detect need three edges before the count moves
        repeat (4) @(posedge clk);
    endtask : send
endmodule : converter_pulse_source

// ===== bench/charge_counter_readout_bench.sv
// self-checking bench for the charge counter readout register bank
`timescale 1ns/100ps
module charge_counter_readout_bench;
    import charge_counter_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [ADDR_W-1:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [DATA_W-1:0] writedata = '0;
    logic [DATA_W-1:0] readdata;
    logic waitrequest;
    logic pulse_rail_a;
    logic pulse_rail_b;
    logic sleep_mode = 1'b0;
    logic [COUNT_W-1:0] cnt [NUM_CH];
    logic [BYTE_W-1:0] old_low;
    logic [DATA_W-1:0] exp_q [$];
    string name_q [$];
    logic [DATA_W-1:0] exp_v;
    string exp_n;
    int failures = 0;
    int n_tests = 0;
    int n;

    always #50 clk = ~clk;

    charge_counter_readout i_charge_counter_readout (.clk(clk), .srst(srst),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .pulse_rail_a(pulse_rail_a),
        .pulse_rail_b(pulse_rail_b), .sleep_mode(sleep_mode));
    converter_pulse_source src_a (.clk(clk), .pulse(pulse_rail_a));
    converter_pulse_source src_b (.clk(clk), .pulse(pulse_rail_b));

    // ****************************************
    // bus master and result monitor
    // ****************************************
    function automatic logic [ADDR_W-1:0] addr_of(input logic [7:0] idx);
        addr_of = ADDR_W'(idx) << 2;
    endfunction : addr_of

    task automatic bus_read(input logic [7:0] idx, input logic [DATA_W-1:0] e, input string nm);
        @(posedge clk);
        exp_q.push_back(e);
        name_q.push_back(nm);
        address <= addr_of(idx);
        read <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        read <= 1'b0;
    endtask : bus_read

    task automatic bus_write(input logic [7:0] idx, input logic [DATA_W-1:0] d);
        @(posedge clk);
        address <= addr_of(idx);
        writedata <= d;
        write <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask : bus_write

    always @(posedge clk)
    begin
        if (read === 1'b1 && waitrequest === 1'b0 && exp_q.size() > 0)
        begin
            exp_v = exp_q.pop_front();
            exp_n = name_q.pop_front();
            n_tests++;
            if (readdata !== exp_v)
            begin
                failures++;
                $display("wrong value %s expected %h seen %h", exp_n, exp_v, readdata);
            end
        end
    end

    // the counter is only addressed while really read, so no steps are lost
    task automatic read_pair(input int c);
        bus_read(HIGH_IDX[c], DATA_W'(cnt[c][15:8]), "high byte");
        bus_read(LOW_IDX[c], DATA_W'(cnt[c][7:0]), "low byte");
    endtask : read_pair

    task automatic pulses(input int c, input int k, input int sel);
        sleep_mode <= (c == 2);
        @(posedge clk);
        if (c == 0)
            src_a.send(k);
        else
            src_b.send(k);
        cnt[c] = cnt[c] + COUNT_W'(k / (int'(PRESCALE_LIMIT[sel]) + 1));
    endtask : pulses

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        n = $urandom(32'h0C91);
        for (int c = 0; c < NUM_CH; c++)
            cnt[c] = COUNT_RESET;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        for (int c = 0; c < NUM_CH; c++)
            read_pair(c);
        bus_read(IDX_CHARGE_COUNTER_CONTROL, '0, "control");
        bus_read(8'h01, '0, "unmapped");
        $display("test reset values done");
        for (int c = 0; c < NUM_CH; c++)
        begin
            n = $urandom_range(40, 1);
            pulses(c, n, 0);
            read_pair(c);
        end
        $display("test random counts done");
        // the shadow must not follow pulses that land after the high byte read
        bus_read(HIGH_IDX[0], DATA_W'(cnt[0][15:8]), "high byte");
        old_low = cnt[0][7:0];
        pulses(0, 3, 0);
        bus_read(LOW_IDX[0], DATA_W'(old_low), "stale shadow");
        read_pair(0);
        $display("test shadow done");
        // steps landing while a high byte is read are kept, so none are lost here
        n = $urandom_range(60, 20);
        fork
            pulses(0, n, 0);
            repeat (20) bus_read(HIGH_IDX[0], DATA_W'(cnt[0][15:8]), "held high");
        join
        read_pair(0);
        $display("test hold done");
        for (int s = 1; s < 4; s++)
        begin
            bus_write(IDX_CHARGE_COUNTER_CONTROL, DATA_W'(s));
            bus_read(IDX_CHARGE_COUNTER_CONTROL, DATA_W'(s), "control");
            pulses(1, 64, s);
            read_pair(1);
        end
        $display("test prescale done");
        bus_write(HIGH_IDX[0], 32'h0000_00FF);
        bus_write(LOW_IDX[0], 32'h0000_00FF);
        read_pair(0);
        $display("test read-only done");
        give_verdict();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        give_verdict();
    end
endmodule : charge_counter_readout_bench
